// ==== src/trc_pkg.sv ====
package trc_pkg;

  typedef enum logic [1:0] {
    TRC_IDLE  = 2'b01,
    TRC_PULSE = 2'b10
  } trc_strobe_t;

  typedef struct packed {
    logic       parity;
    logic [7:0] data;
  } trc_char_t;

  typedef struct packed {
    logic        hi_s1;
    logic        hi_s2;
    logic        xl_s1;
    logic        xl_s2;
    logic        wr_s1;
    logic        wr_s2;
    logic        ck_s1;
    logic        ck_s2;
    logic        ck_s3;
    trc_char_t   ch_s1;
    trc_char_t   ch_s2;
    logic [15:0] period;
    logic [15:0] cnt;
    logic [15:0] stb_cnt;
    trc_strobe_t fsm;
    logic        strobe;
    trc_char_t   rd_char;
    logic [1:0]  thr;
    logic [7:0]  thr_pct;
    logic [8:0]  crc;
    logic [8:0]  lrc;
    logic [15:0] chars;
    logic        dual_stack;
    logic        read_en;
    logic        xl_conflict;
    logic [31:0] rdata;
  } trc_state_t;

endpackage

// ==== src/trc_read_side.sv ====
// Function
// R1: Controller XORs each character into the nine-bit check shift register.
// R2: Check register then rotates right, parity stage wrapping into stage zero.
// R3: If wrapped bit is one, stages two to five are inverted.
// R4: Check register advances exactly once per data character, no extra shift.
// R5: Cyclic check character is final contents inverted except stages two and four.
// R6: Reverse reads reverse bit significance before entering the check register.
// R7: Cyclic check odd parity for even character count, even for odd count.
// R8: Controller always writes a correct cyclic check character on nine-track.
// R9: Erased gap made by write command with write strobes suppressed.
// R10: High threshold line selects fifty percent level, for verify reads only.
// R11: With threshold lines deasserted, read signals clip at twenty percent.
// R12: Extra-low line selects ten percent, only with high line deasserted.
// R13: Dual-stack units pick threshold from the write status flag.
// R14: Controller keeps threshold lines unchanged across each record.
// R15: One read strobe per character; data sampled on its trailing edge. Here a character arriving during a pulse gets no strobe of its own.
// R16: Read strobe lasts nominally 46 percent of a character period.
// R17: Controller ignores read data during the pre-record delay.
// R18: First strobe of a record arms both gap detectors.
// R19: After 2.5 idle periods a 3-period window catches the cyclic check.
// R20: Characters after that window are the longitudinal check character.
// R21: After 16 idle periods controller stops reads and forward motion.
// R22: Each character is parity checked and accumulated into both check registers.
// R23: Reverse reads see check characters first; post-record delay before stop.
// R24: File mark is one character equal to its longitudinal check, fixed pattern.
// R25: Nine-track data odd vertical parity, seven-track BCD even.
`include "trc_regs.svh"

module trc_read_side (
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic                char_clk,
  input  wire trc_pkg::trc_char_t  head_char,
  input  wire logic                high_threshold_select,
  input  wire logic                extra_low_threshold_select,
  input  wire logic                write_status_flag,
  input  wire logic [3:0]          addr,
  input  wire logic [31:0]         wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic [31:0]              rdata,
  output logic                     read_char_strobe,
  output logic                     read_parity_line,
  output logic [7:0]               read_data_lines,
  output logic [1:0]               threshold_code,
  output logic [7:0]               threshold_pct
);
  import trc_pkg::*;

  trc_state_t state;
  trc_state_t next_state;

  // ==========================================================
  // Helpers
  // Never shorter than one cycle, even for a very short period
  function automatic logic [15:0] strobe_width(input logic [15:0] period);
    logic [31:0] w;
    w = ({16'h0000, period} * `TRC_STROBE_PCT) / `TRC_PCT_DIV;
    if (w[15:0] == 16'h0000) begin
      strobe_width = 16'h0001;
    end else begin
      strobe_width = w[15:0];
    end
  endfunction

  // One character into the check register: exclusive-OR, rotate right, feedback
  function automatic logic [8:0] crc_step(input logic [8:0] crc, input logic [8:0] ch);
    logic [8:0] x;
    logic [8:0] r;
    x = crc ^ ch;
    r = {x[7:0], x[8]};
    if (r[0]) begin
      r = r ^ `TRC_CRC_FEEDBACK;
    end
    crc_step = r;
  endfunction

  // Cyclic check character as it would go to tape; stages two and four stay true
  logic [8:0] cyclic_check_character;
  assign cyclic_check_character = state.crc ^ `TRC_CRC_OUT_MASK;

  // ==========================================================
  // Next state
  always_comb begin
    logic edge_seen;
    logic [8:0] ch9;
    edge_seen = 1'b0;
    ch9 = 9'h000;
    next_state = state;

    // ==========================================================
    // Synchronisers
    // Pins from the transport domain pass two stages first
    next_state.hi_s1 = high_threshold_select;
    next_state.hi_s2 = state.hi_s1;
    next_state.xl_s1 = extra_low_threshold_select;
    next_state.xl_s2 = state.xl_s1;
    next_state.wr_s1 = write_status_flag;
    next_state.wr_s2 = state.wr_s1;
    next_state.ck_s1 = char_clk;
    next_state.ck_s2 = state.ck_s1;
    next_state.ck_s3 = state.ck_s2;
    next_state.ch_s1 = head_char;
    next_state.ch_s2 = state.ch_s1;

    edge_seen = state.ck_s2 && !state.ck_s3;
    ch9 = {state.ch_s2.parity, state.ch_s2.data};

    // ==========================================================
    // Threshold selection
    if (state.dual_stack) begin
      if (state.wr_s2) begin
        next_state.thr = `TRC_THR_HIGH; // [R13]
      end else if (state.xl_s2) begin
        next_state.thr = `TRC_THR_XLOW; // [R13]
      end else begin
        next_state.thr = `TRC_THR_LOW; // [R13]
      end
      next_state.xl_conflict = 1'b0;
    end else begin
      if (state.hi_s2) begin
        // High line wins; extra-low needs it released
        next_state.thr = `TRC_THR_HIGH; // [R10] [R12]
      end else if (state.xl_s2) begin
        next_state.thr = `TRC_THR_XLOW; // [R12]
      end else begin
        next_state.thr = `TRC_THR_LOW; // [R11]
      end
      // Conflict is only reported; the transport still sees the high level
      next_state.xl_conflict = state.hi_s2 && state.xl_s2; // [R12]
    end
    unique case (next_state.thr)
      `TRC_THR_HIGH: next_state.thr_pct = `TRC_PCT_HIGH; // [R10]
      `TRC_THR_XLOW: next_state.thr_pct = `TRC_PCT_XLOW; // [R12]
      default:       next_state.thr_pct = `TRC_PCT_LOW; // [R11]
    endcase

    // ==========================================================
    // Character period measurement, saturating on long gaps
    // A gap beyond the counter reads as the maximum rather than wrapping short
    if (edge_seen) begin
      next_state.period = state.cnt;
      next_state.cnt = 16'h0001;
    end else if (state.cnt != `TRC_PERIOD_MAX) begin
      next_state.cnt = state.cnt + 16'h0001;
    end

    // ==========================================================
    // Strobe generator: data set at the leading edge, steady to the trailing edge
    // A new edge during a pulse reloads its count; the strobe stays high, so that character gets no rising edge of its own
    unique case (state.fsm)
      TRC_IDLE: begin
        next_state.strobe = 1'b0;
      end
      TRC_PULSE: begin
        if (state.stb_cnt <= 16'h0001) begin
          next_state.fsm = TRC_IDLE;
          next_state.strobe = 1'b0; // [R15]
        end else begin
          next_state.stb_cnt = state.stb_cnt - 16'h0001;
        end
      end
    endcase
    if (edge_seen && state.read_en) begin
      next_state.fsm = TRC_PULSE;
      next_state.strobe = 1'b1; // [R15]
      // Width follows the gap this edge just closed, so the long idle gap stretches the first pulse after idle
      next_state.stb_cnt = strobe_width(state.cnt); // [R16]
      // Accepted character: latch it and fold it into both check registers
      next_state.rd_char = state.ch_s2;
      next_state.crc = crc_step(state.crc, ch9); // [R7]
      next_state.lrc = state.lrc ^ ch9; // [R7]
      next_state.chars = state.chars + 16'h0001;
    end

    // ==========================================================
    // Register bus
    // Read data stand for one cycle only, zero otherwise
    next_state.rdata = 32'h0000_0000;
    if (wr && addr == `TRC_REG_CTRL) begin
      next_state.dual_stack = wdata[`TRC_CTRL_DUAL_STACK];
      next_state.read_en = wdata[`TRC_CTRL_READ_EN];
      if (wdata[`TRC_CTRL_CLEAR]) begin
        // Clear starts a new record; a character in the same cycle is still strobed out but left out of both check registers and the count
        next_state.crc = 9'h000;
        next_state.lrc = 9'h000;
        next_state.chars = 16'h0000;
      end
    end
    if (rd) begin
      unique case (addr)
        `TRC_REG_CTRL:   next_state.rdata = {30'h0000_0000, state.read_en, state.dual_stack};
        // CRC parity against LRC parity shows the check property live
        `TRC_REG_STATUS: next_state.rdata = {11'h000, state.chars, ^cyclic_check_character, ^state.lrc ^ ^cyclic_check_character,
                                             state.xl_conflict, state.thr}; // [R7]
        `TRC_REG_PERIOD: next_state.rdata = {16'h0000, state.period};
        `TRC_REG_CHECK:  next_state.rdata = {7'h00, state.lrc, 7'h00, cyclic_check_character};
        default:         next_state.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      // Threshold comes up at the normal low clip level
      state <= '{fsm: TRC_IDLE, thr: `TRC_THR_LOW, thr_pct: `TRC_PCT_LOW, default: '0};
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata = state.rdata;
  assign read_char_strobe = state.strobe;
  assign read_parity_line = state.rd_char.parity;
  assign read_data_lines = state.rd_char.data;
  assign threshold_code = state.thr;
  assign threshold_pct = state.thr_pct;

endmodule

// ==== src/trc_regs.svh ====
`ifndef TRC_REGS_SVH
`define TRC_REGS_SVH

// ==========================================================
// Register offsets
`define TRC_REG_CTRL    4'h0
`define TRC_REG_STATUS  4'h4
`define TRC_REG_PERIOD  4'h8
`define TRC_REG_CHECK   4'hC

// ==========================================================
// Control fields
`define TRC_CTRL_DUAL_STACK  0
`define TRC_CTRL_READ_EN     1
`define TRC_CTRL_CLEAR       2
`define TRC_CTRL_RESET       3'h0

// ==========================================================
// Threshold codes
`define TRC_THR_LOW   2'h0
`define TRC_THR_HIGH  2'h1
`define TRC_THR_XLOW  2'h2

// ==========================================================
// Nominal clip levels, percent of nominal amplitude
`define TRC_PCT_HIGH  8'h32
`define TRC_PCT_LOW   8'h14
`define TRC_PCT_XLOW  8'h0A

// ==========================================================
// Timing and check constants
`define TRC_STROBE_PCT   46
`define TRC_PCT_DIV      100
`define TRC_PERIOD_MAX   16'hFFFF
`define TRC_CRC_OUT_MASK 9'h1EB
`define TRC_CRC_FEEDBACK 9'h03C

`endif

// ==== verif/trc_head_model.sv ====
module trc_head_model (
  output logic               char_clk,
  output trc_pkg::trc_char_t head_char
);
  timeunit 1ns;
  timeprecision 1ns;
  import trc_pkg::*;
  initial begin
    char_clk = 1'b0;
    head_char = 9'h000;
  end
  // ==========
  // One character per 400 ns; clock stands low and data turn over between frames
  task automatic send(input logic [8:0] c, input bit last);
    head_char = c;
    #17 char_clk = 1'b1;
    #200 char_clk = 1'b0;
    #183 if (last) head_char = ~c;
  endtask
endmodule

// ==== verif/trc_read_side_sva.sv ====
module trc_read_side_sva (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        char_clk,
  input wire logic        high_threshold_select,
  input wire logic        extra_low_threshold_select,
  input wire logic        write_status_flag,
  input wire logic [3:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        read_char_strobe,
  input wire logic        read_parity_line,
  input wire logic [7:0]  read_data_lines,
  input wire logic [1:0]  threshold_code,
  input wire logic [7:0]  threshold_pct
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        en;
  logic        cc_q;
  logic [15:0] gap;
  logic [15:0] p1;
  wire         hi = high_threshold_select;
  wire         xl = extra_low_threshold_select;
  wire         ws = write_status_flag;
  // ==========
  // Read enable mirror and last character period; pulse width depends on it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      en   <= 1'b0;
      cc_q <= 1'b0;
      gap  <= 16'h0000;
      p1   <= 16'h0000;
    end else begin
      cc_q <= char_clk;
      if (wr && addr == 4'h0) begin
        en <= wdata[1];
      end
      if (char_clk && !cc_q) begin
        p1  <= gap + 16'h0001;
        gap <= 16'h0000;
      end else begin
        gap <= gap + 16'h0001;
      end
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ==========
  // Pins need four samples to pass the synchroniser
  a_low_clip: assert property ((!hi && !xl && !ws) [*4] |-> threshold_code == 2'h0)
    else $error("low threshold missing");
  a_high_sel: assert property ((hi && ws) [*4] |-> threshold_code == 2'h1)
    else $error("high threshold missing");
  a_xlow_sel: assert property ((xl && !hi && !ws) [*4] |-> threshold_code == 2'h2)
    else $error("extra low threshold missing");
  a_pct_map: assert property (
    threshold_pct == (threshold_code == 2'h1 ? 8'h32 : threshold_code == 2'h2 ? 8'h0A : 8'h14))
    else $error("clip level wrong");
  a_strobe_out: assert property (
    $rose(char_clk) && en && !read_char_strobe |-> ##[2:4] $rose(read_char_strobe))
    else $error("strobe missing");
  a_strobe_gate: assert property ($rose(read_char_strobe) |-> en)
    else $error("strobe while disabled");
  a_data_hold: assert property (!$rose(read_char_strobe) |-> $stable({read_parity_line, read_data_lines}))
    else $error("data lines moved");
  a_strobe_width: assert property (
    $rose(read_char_strobe) && p1 == 16'h0008 |-> read_char_strobe [*3] ##1 !read_char_strobe)
    else $error("strobe width wrong");
  c_strobe: cover property ($rose(read_char_strobe));
  c_high: cover property (threshold_code == 2'h1);
  c_xlow: cover property (threshold_code == 2'h2);
endmodule

bind trc_read_side trc_read_side_sva SVA (.*);

// ==== verif/trc_read_side_tb.sv ====
module trc_read_side_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import trc_pkg::*;
  logic        sys_clk = 1'b0, reset = 1'b1, hi = 1'b0, xl = 1'b0, ws = 1'b0;
  logic        wr = 1'b0, rd = 1'b0, rd_d = 1'b0, st_d = 1'b0, stb, par;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [7:0]  dat, pct;
  logic [1:0]  code, e;
  wire         char_clk;
  trc_char_t   head_char;
  logic [31:0] eq[$], mq[$];
  logic [8:0]  sq[$];
  int          failures = 0, samples_checked = 0, cyc = 0;
  trc_head_model P (.char_clk(char_clk), .head_char(head_char));
  trc_read_side DUT (.sys_clk(sys_clk), .reset(reset), .char_clk(char_clk), .head_char(head_char),
    .high_threshold_select(hi), .extra_low_threshold_select(xl), .write_status_flag(ws), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .read_char_strobe(stb), .read_parity_line(par),
    .read_data_lines(dat), .threshold_code(code), .threshold_pct(pct));
  initial forever #25 sys_clk = ~sys_clk;
  task automatic check(input string n, input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========
  // Reads note the masked expectation; the monitor compares a cycle later
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
    if (!w) eq.push_back(d & m);
    if (!w) mq.push_back(m);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge sys_clk);
    {wr, rd} <= 2'b00;
    @(posedge sys_clk);
  endtask
  // A disabled lead character sets the period so every data strobe is short
  task automatic rec(input int n);
    logic [8:0] c;
    logic [8:0] crc;
    logic [8:0] lrc;
    crc = '0;
    lrc = '0;
    fork
      for (int i = 0; i <= n; i++) begin
        c = {1'b0, 8'($urandom)};
        c[8] = ~^c[7:0];
        if (n == 1 && i == 1) c = 9'h013;
        if (i > 0) begin
          sq.push_back(c);
          lrc ^= c;
          crc ^= c;
          crc = {crc[7:0], crc[8]};
          if (crc[0]) crc ^= 9'h03C;
        end
        P.send(c, i == n);
      end
      begin
        @(posedge char_clk);
        repeat (5) @(posedge sys_clk);
        bus(1, 4'h0, 32'h6, 0);
      end
    join
    repeat (128) @(posedge sys_clk);
    bus(1, 4'h0, 32'h0, 0);
    bus(0, 4'hC, {7'h0, lrc, 7'h0, crc ^ 9'h1EB}, 32'h01FF01FF);
    bus(0, 4'h4, {n[15:0], ~n[0], 4'h8}, 32'h001FFFF8);
    bus(0, 4'h8, 32'h8, 32'hFFFF);
  endtask
  always @(posedge sys_clk) begin
    rd_d <= rd;
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      give_verdict();
    end
  end
  always @(negedge sys_clk) begin
    if (rd_d) check("rdata", rdata & mq.pop_front(), eq.pop_front());
    if (stb && !st_d) check("char", {par, dat}, sq.size() ? sq.pop_front() : 'x);
    st_d = stb;
  end
  initial begin
    void'($urandom(32'h2F1635DD));
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    bus(0, 4'h2, 32'h0, 32'hFFFFFFFF);
    bus(0, 4'h4, 32'h0, 32'h3);
    for (int i = 0; i < 16; i++) begin
      bus(1, 4'h0, i >> 3, 0);
      hi <= i[0];
      xl <= i[1];
      ws <= i[2];
      repeat (5) @(posedge sys_clk);
      e = (i[3] ? i[2] : i[0]) ? 2'h1 : i[1] ? 2'h2 : 2'h0;
      check("code", code, e);
      check("pct", pct, e == 2'h1 ? 8'h32 : e == 2'h2 ? 8'h0A : 8'h14);
      bus(0, 4'h4, {i[0] & i[1] & !i[3], e}, i[3] ? 3 : 7);
    end
    // Threshold pins stay put while records run
    for (int r = 1; r < 5; r++) rec(r < 3 ? r : $urandom_range(20, 3));
    check("left", sq.size(), 0);
    give_verdict();
  end
endmodule
